// >>> src/sacc_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef SACC_MAP_SVH
`define SACC_MAP_SVH

`define SACC_OFF_CTRL_A 8'h00
`define SACC_OFF_CTRL_B 8'h04
`define SACC_OFF_INSEL 8'h08
`define SACC_OFF_RES_LO 8'h0c
`define SACC_OFF_RES_HI 8'h10
`define SACC_OFF_PWR 8'h14

`define SACC_A_EN 7
`define SACC_A_START 6
`define SACC_A_AUTO 5
`define SACC_A_FLAG 4
`define SACC_A_PS_LO 0
`define SACC_B_TS_LO 0
`define SACC_I_REF_LO 6
`define SACC_I_LADJ 5
`define SACC_I_CH_LO 0
`define SACC_P_GATE 0

`define SACC_RST_PS 3'h0
`define SACC_RST_TS 3'h0
`define SACC_RST_CH 5'h00
`define SACC_RST_REF 2'h0
`define SACC_RST_GATE 1'b1

`define SACC_LEN_NORMAL 5'd13
`define SACC_LEN_FIRST 5'd25
`define SACC_LEN_DIFF 5'd14
`define SACC_SH_NORMAL 5'd1
`define SACC_SH_FIRST 5'd13
`define SACC_SH_AUTO 5'd2
`define SACC_SYNC_CYC 3
`define SACC_TS_SELF 3'h0
`define SACC_CH_DIFF_LO 5'h08
`define SACC_CH_DIFF_HI 5'h1d

`endif

// >>> src/sacc_pkg.sv
// Types shared by the converter control logic
package sacc_pkg;

    typedef enum logic {
        SACC_IDLE,
        SACC_CONV
    } sacc_mode_t;

    typedef struct packed {
        sacc_mode_t st;
        logic ctl_en;
        logic start;
        logic auto_en;
        logic flag;
        logic [2:0] ps;
        logic [2:0] tsel;
        logic pgate;
        logic [1:0] refsel;
        logic ladj;
        logic [4:0] chsel;
        logic [4:0] act_ch;
        logic [1:0] act_ref;
        logic [9:0] res;
        logic lock;
        logic [7:0] pcnt;
        logic half;
        logic [4:0] ccnt;
        logic [4:0] clen;
        logic [4:0] shat;
        logic first;
        logic trig_prev;
        logic [2:0] sync;
        logic sh;
        logic done;
        logic [31:0] prdata;
    } sacc_state_t;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } sacc_apb_req_t;

endpackage

// >>> src/sacc_top.sv
// Conversion control for a 10-bit successive-approximation converter with APB registers
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "sacc_map.svh"

// Notes on behaviour
// - Runs only when enabled and ungated
// - Five-bit field selects the analog input
// - Result right-aligned, left when left_adjust set
// - Low byte read locks result until high
// - Discarded result still raises completion flag
// - Start bit starts, reads one, self-clears
// - Channel change waits for running conversion
// - Auto trigger starts from selected source
// - Trigger edge resets prescaler; busy edges ignored
// - Source flag must clear before next edge
// - Own completion flag trigger free-runs
// - Software start works; start reads one busy
// - Prescaler runs when enabled, reset otherwise
// - Software start begins on next converter edge
// - Conversion 13 cycles, first one 25
// - Sample at 1.5, first at 13.5
// - Completion stores result, sets flag, clears start
// - Auto sample two cycles after edge plus sync
// - Free-running restarts, start stays high
// - Reference select picks supply, internal, external
// - Selections frozen during conversion, buffered otherwise
// - Differential on high half-rate clock takes 14
module sacc_top #(
    parameter int NTRIG = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire sacc_pkg::sacc_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NTRIG-1:0] trig_in,
    input wire logic [9:0] adc_result,
    output logic analog_enable,
    output logic conv_busy,
    output logic conv_done,
    output logic sample_hold,
    output logic [4:0] active_channel,
    output logic [1:0] active_reference,
    output logic half_rate_converter_clock
);

    sacc_pkg::sacc_state_t s_q;
    sacc_pkg::sacc_state_t s_d;

    logic run;
    logic tick;
    logic [7:0] div_last;
    logic acc;
    logic wr;
    logic rd;
    logic last_tick;
    logic free_mode;
    logic trig_lvl;
    logic trig_edge;
    logic is_diff;
    logic [31:0] rd_word;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `SACC_OFF_CTRL_A) || (a == `SACC_OFF_CTRL_B)
            || (a == `SACC_OFF_INSEL) || (a == `SACC_OFF_RES_LO)
            || (a == `SACC_OFF_RES_HI) || (a == `SACC_OFF_PWR);
    endfunction

    // Presentation only; stored value and lock untouched
    function automatic logic [7:0] res_byte(input logic [9:0] r, input logic la,
            input logic hi);
        if (la) begin
            res_byte = hi ? r[9:2] : {r[1:0], 6'h00};
        end else begin
            res_byte = hi ? {6'h00, r[9:8]} : r[7:0];
        end
    endfunction

    assign run = s_q.ctl_en & ~s_q.pgate;
    assign div_last = (s_q.ps == 3'h0) ? 8'h01 : ((8'h01 << s_q.ps) - 8'h01);
    // A shorter division written mid-count must not wait for the counter to wrap
    assign tick = ce & run & (s_q.pcnt >= div_last);
    assign acc = apb.psel & apb.penable;
    assign wr = acc & apb.pwrite;
    assign rd = acc & ~apb.pwrite;
    assign last_tick = tick & (s_q.st == sacc_pkg::SACC_CONV)
        & (s_q.ccnt == s_q.clen - 5'd1);
    assign free_mode = s_q.auto_en & (s_q.tsel == `SACC_TS_SELF);
    assign is_diff = (s_q.act_ch >= `SACC_CH_DIFF_LO) && (s_q.act_ch <= `SACC_CH_DIFF_HI);
    // Other sources are outside flags; the edge only recurs once they clear
    assign trig_lvl = (s_q.tsel == `SACC_TS_SELF) ? 1'b0 : trig_in[s_q.tsel];
    assign trig_edge = trig_lvl & ~s_q.trig_prev;

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (apb.paddr)
            `SACC_OFF_CTRL_A: begin
                rd_word[`SACC_A_EN] = s_q.ctl_en;
                rd_word[`SACC_A_START] = s_q.start;
                rd_word[`SACC_A_AUTO] = s_q.auto_en;
                rd_word[`SACC_A_FLAG] = s_q.flag;
                rd_word[`SACC_A_PS_LO +: 3] = s_q.ps;
            end
            `SACC_OFF_CTRL_B: rd_word[`SACC_B_TS_LO +: 3] = s_q.tsel;
            `SACC_OFF_INSEL: begin
                rd_word[`SACC_I_REF_LO +: 2] = s_q.refsel;
                rd_word[`SACC_I_LADJ] = s_q.ladj;
                rd_word[`SACC_I_CH_LO +: 5] = s_q.chsel;
            end
            `SACC_OFF_RES_LO: rd_word[7:0] = res_byte(s_q.res, s_q.ladj, 1'b0);
            `SACC_OFF_RES_HI: rd_word[7:0] = res_byte(s_q.res, s_q.ladj, 1'b1);
            `SACC_OFF_PWR: rd_word[`SACC_P_GATE] = s_q.pgate;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.sh = 1'b0;
        s_d.done = 1'b0;
        if (ce) begin
            // Read data is captured in setup so the bus sees a flop
            if (apb.psel & ~apb.penable) begin
                s_d.prdata = rd_word;
            end
            if (wr) begin
                unique case (apb.paddr)
                    `SACC_OFF_CTRL_A: begin
                        s_d.ctl_en = apb.pwdata[`SACC_A_EN];
                        s_d.auto_en = apb.pwdata[`SACC_A_AUTO];
                        s_d.ps = apb.pwdata[`SACC_A_PS_LO +: 3];
                        if (apb.pwdata[`SACC_A_FLAG]) begin
                            s_d.flag = 1'b0;
                        end
                        if (apb.pwdata[`SACC_A_START]) begin
                            s_d.start = 1'b1;
                        end
                    end
                    `SACC_OFF_CTRL_B: s_d.tsel = apb.pwdata[`SACC_B_TS_LO +: 3];
                    `SACC_OFF_INSEL: begin
                        s_d.refsel = apb.pwdata[`SACC_I_REF_LO +: 2];
                        s_d.ladj = apb.pwdata[`SACC_I_LADJ];
                        s_d.chsel = apb.pwdata[`SACC_I_CH_LO +: 5];
                    end
                    `SACC_OFF_PWR: s_d.pgate = apb.pwdata[`SACC_P_GATE];
                    default: s_d.pgate = s_q.pgate;
                endcase
            end
            if (rd && apb.paddr == `SACC_OFF_RES_LO) begin
                s_d.lock = 1'b1;
            end
            if (rd && apb.paddr == `SACC_OFF_RES_HI) begin
                s_d.lock = 1'b0;
            end

            s_d.pcnt = tick ? 8'h00 : s_q.pcnt + 8'h01;
            if (tick) begin
                s_d.half = ~s_q.half;
            end
            s_d.trig_prev = trig_lvl;
            s_d.sync = {s_q.sync[1:0], 1'b0};

            // Live selection follows the register while running, except mid-conversion
            if (run && (s_q.st == sacc_pkg::SACC_IDLE || last_tick)) begin
                s_d.act_ch = s_q.chsel;
                s_d.act_ref = s_q.refsel;
            end

            unique case (s_q.st)
                sacc_pkg::SACC_IDLE: begin
                    if (s_q.auto_en && trig_edge && s_q.sync == 3'h0) begin
                        s_d.sync[0] = 1'b1;
                    end
                    if (s_q.sync[`SACC_SYNC_CYC-1]) begin
                        s_d.pcnt = 8'h00;
                        s_d.half = 1'b0;
                        s_d.start = 1'b1;
                        s_d.st = sacc_pkg::SACC_CONV;
                        s_d.ccnt = 5'd0;
                        s_d.clen = s_q.first ? `SACC_LEN_FIRST : `SACC_LEN_NORMAL;
                        s_d.shat = s_q.first ? `SACC_SH_FIRST : `SACC_SH_AUTO;
                    end else if (s_q.start && tick) begin
                        s_d.st = sacc_pkg::SACC_CONV;
                        s_d.ccnt = 5'd0;
                        if (s_q.first) begin
                            s_d.clen = `SACC_LEN_FIRST;
                            s_d.shat = `SACC_SH_FIRST;
                        end else begin
                            s_d.clen = (is_diff && s_q.half) ? `SACC_LEN_DIFF
                                : `SACC_LEN_NORMAL;
                            s_d.shat = `SACC_SH_NORMAL;
                        end
                    end
                end
                sacc_pkg::SACC_CONV: begin
                    s_d.start = 1'b1;
                    if (tick) begin
                        s_d.ccnt = s_q.ccnt + 5'd1;
                        // Sampling on the tick after the half-cycle point
                        if (s_q.ccnt == s_q.shat) begin
                            s_d.sh = 1'b1;
                        end
                    end
                    if (last_tick) begin
                        s_d.done = 1'b1;
                        s_d.flag = 1'b1;
                        s_d.first = 1'b0;
                        if (!s_q.lock) begin
                            s_d.res = adc_result;
                        end
                        if (free_mode) begin
                            s_d.ccnt = 5'd0;
                            s_d.clen = is_diff ? `SACC_LEN_DIFF : `SACC_LEN_NORMAL;
                            s_d.shat = `SACC_SH_NORMAL;
                        end else begin
                            s_d.start = 1'b0;
                            s_d.st = sacc_pkg::SACC_IDLE;
                        end
                    end
                end
            endcase

            // Disabling aborts any conversion; next run counts as first
            if (!run) begin
                s_d.pcnt = 8'h00;
                s_d.half = 1'b0;
                s_d.st = sacc_pkg::SACC_IDLE;
                s_d.start = 1'b0;
                s_d.sync = 3'h0;
                s_d.first = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: sacc_pkg::SACC_IDLE, ps: `SACC_RST_PS, tsel: `SACC_RST_TS,
                pgate: `SACC_RST_GATE, refsel: `SACC_RST_REF, chsel: `SACC_RST_CH,
                act_ch: `SACC_RST_CH, act_ref: `SACC_RST_REF, first: 1'b1,
                default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = 1'b1;
    assign pslverr = acc & ~addr_hit(apb.paddr);
    assign analog_enable = run;
    assign conv_busy = (s_q.st == sacc_pkg::SACC_CONV);
    assign conv_done = s_q.done;
    assign sample_hold = s_q.sh;
    assign active_channel = s_q.act_ch;
    assign active_reference = s_q.act_ref;
    assign half_rate_converter_clock = s_q.half;

    // Checks
    flag_on_done_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && last_tick |=> s_q.flag && s_q.done)
        else $error("completion did not raise flag");

    lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.lock && !(rd && apb.paddr == `SACC_OFF_RES_HI) |=> $stable(s_q.res))
        else $error("locked result changed");

    busy_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_busy |-> s_q.start)
        else $error("start bit low during conversion");

    prescale_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !run |=> s_q.pcnt == 8'h00 && !conv_busy)
        else $error("prescaler not reset while disabled");

    sel_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_busy && !last_tick |=> $stable(s_q.act_ch) && $stable(s_q.act_ref))
        else $error("selection changed mid-conversion");

    first_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && run && !conv_busy && s_q.first && s_q.start && tick
        |=> s_q.clen == `SACC_LEN_FIRST && s_q.shat == `SACC_SH_FIRST)
        else $error("first conversion length wrong");

    single_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && run && last_tick && !free_mode |=> !s_q.start && !conv_busy)
        else $error("single conversion left start set");

    free_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && run && last_tick && free_mode |=> conv_busy && s_q.start && s_q.ccnt == 5'd0)
        else $error("free-running did not restart");

    auto_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && run && !conv_busy && s_q.auto_en && trig_edge && s_q.sync == 3'h0
        ##1 ce [*2] ##1 ce && run |=> conv_busy && s_q.shat == `SACC_SH_AUTO
        || s_q.clen == `SACC_LEN_FIRST)
        else $error("auto trigger not started after sync");

endmodule // sacc_top

// >>> verification/sacc_src_model.sv
// Model of the trigger sources and the comparator feeding the converter control
`timescale 1ns/1ps
module sacc_src_model #(
    parameter int NTRIG = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire,
    input wire logic clr,
    input wire logic [2:0] idx,
    input wire logic [9:0] val,
    output logic [NTRIG-1:0] trig_in,
    output logic [9:0] adc_result
);
    // Comparator value only matters on the completion cycle, so it is passed through
    assign adc_result = val;
    // Each source flag stays set until software clears it, masked or not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_in <= '0;
        end else if (clr) begin
            trig_in <= '0;
        end else if (fire) begin
            trig_in[idx] <= 1'b1;
        end
    end
endmodule // sacc_src_model

// >>> verification/tb_sar_adc_conversion_control.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sacc_map.svh"
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb_sar_adc_conversion_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    sacc_pkg::sacc_apb_req_t apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, analog_enable, conv_busy, conv_done, sample_hold, hrc;
    logic [4:0] active_channel;
    logic [1:0] active_reference;
    logic [7:0] trig_in;
    logic [9:0] adc_result;
    logic ce_r = 1'b1;
    logic fire = 1'b0;
    logic clr = 1'b0;
    logic [2:0] idx = 3'h0;
    logic [9:0] val = 10'h000;
    logic [9:0] r1, r2;
    logic [31:0] exp_q[$];
    logic [31:0] e;
    int mismatches = 0;
    int check_count = 0;
    int done_cnt = 0;
    int sh_cnt = 0;
    int bc, d0;
    always #12.5 pclk = ~pclk;
    sacc_top #(.NTRIG(8)) DUT (.pclk(pclk), .presetn(presetn), .ce(ce_r), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
        .adc_result(adc_result), .analog_enable(analog_enable), .conv_busy(conv_busy),
        .conv_done(conv_done), .sample_hold(sample_hold), .active_channel(active_channel),
        .active_reference(active_reference), .half_rate_converter_clock(hrc));
    sacc_src_model #(.NTRIG(8)) src (.pclk(pclk), .presetn(presetn), .fire(fire), .clr(clr),
        .idx(idx), .val(val), .trig_in(trig_in), .adc_result(adc_result));
    // Read data is judged at the access edge against the oldest note
    always @(posedge pclk) begin
        if (apb.psel && apb.penable && pready && !apb.pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK("prdata", e, prdata)
        end
        if (apb.psel && apb.penable && pready) begin
            `CHK("pslverr", (apb.paddr > `SACC_OFF_PWR) || (apb.paddr[1:0] != 2'b00), pslverr)
        end
        if (conv_done) done_cnt++;
        if (conv_busy === 1'b1) bc++;
        if (sample_hold) sh_cnt++;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb.psel <= 1'b1;
        apb.paddr <= a;
        apb.pwrite <= w;
        apb.pwdata <= d;
        @(posedge pclk);
        apb.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            wrap_up();
        end
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        exp_q.push_back(x);
        apb_xfer(a, 1'b0, 32'h0);
    endtask
    // Bounded wait for completion, failing the run when the limit is reached
    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) begin
            mismatches++;
            wrap_up();
        end
    endtask
    function automatic logic near(input int got, input int want);
        return (got >= want - 1 && got <= want + 1);
    endfunction
    initial begin
        void'($urandom(32'hcb96a256));
        r1 = 10'($urandom);
        r2 = 10'($urandom);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        rd(`SACC_OFF_CTRL_A, 32'h0);
        rd(`SACC_OFF_PWR, 32'h1);
        rd(8'h3c, 32'h0);
        `CHK("off_enable", 1'b0, analog_enable)
        wr(`SACC_OFF_CTRL_A, 32'h80);
        @(negedge pclk);
        `CHK("gated_enable", 1'b0, analog_enable)
        // First conversion after enable on channel 3, internal reference
        val <= r1;
        wr(`SACC_OFF_PWR, 32'h0);
        wr(`SACC_OFF_INSEL, 32'h43);
        bc = 0;
        wr(`SACC_OFF_CTRL_A, 32'hc0);
        @(negedge pclk);
        `CHK("run_enable", 1'b1, analog_enable)
        wait_done(200);
        `CHK("first_len", 1'b1, near(bc, 50))
        @(posedge pclk);
        `CHK("channel", 5'h03, active_channel)
        `CHK("reference", 2'h1, active_reference)
        rd(`SACC_OFF_CTRL_A, 32'h90);
        rd(`SACC_OFF_RES_LO, {24'h0, r1[7:0]});
        rd(`SACC_OFF_RES_HI, {30'h0, r1[9:8]});
        // Slower prescaler; channel change in mid-conversion waits
        val <= r2;
        bc = 0;
        // Fast division keeps runs short; analog resolution is not modelled
        wr(`SACC_OFF_CTRL_A, 32'hd3);
        d0 = 0;
        while (conv_busy !== 1'b1 && d0 < 100) begin
            @(posedge pclk);
            d0++;
        end
        if (d0 >= 100) begin
            mismatches++;
            wrap_up();
        end
        wr(`SACC_OFF_INSEL, 32'h65);
        @(negedge pclk);
        `CHK("held_channel", 5'h03, active_channel)
        wait_done(400);
        `CHK("normal_len", 1'b1, near(bc, 104))
        @(posedge pclk);
        `CHK("new_channel", 5'h05, active_channel)
        rd(`SACC_OFF_CTRL_A, 32'h93);
        // Left presentation, then a completion while locked is lost
        rd(`SACC_OFF_RES_LO, {24'h0, r2[1:0], 6'h00});
        val <= r1;
        wr(`SACC_OFF_CTRL_A, 32'hd0);
        wait_done(200);
        rd(`SACC_OFF_CTRL_A, 32'h90);
        rd(`SACC_OFF_RES_HI, {24'h0, r2[9:2]});
        rd(`SACC_OFF_RES_LO, {24'h0, r2[1:0], 6'h00});
        // Auto trigger from source 2; a held trigger does not restart
        wr(`SACC_OFF_CTRL_B, 32'h2);
        wr(`SACC_OFF_CTRL_A, 32'hb0);
        d0 = done_cnt;
        @(posedge pclk);
        idx <= 3'h2;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(`SACC_OFF_CTRL_A, 32'he0);
        wait_done(200);
        repeat (100) @(posedge pclk);
        `CHK("one_auto", d0 + 1, done_cnt)
        // Flag cleared at the source, then a new edge starts again
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
        wait_done(200);
        @(posedge pclk);
        `CHK("two_auto", d0 + 2, done_cnt)
        // Free running on own completion flag
        wr(`SACC_OFF_CTRL_B, 32'h0);
        wr(`SACC_OFF_CTRL_A, 32'hf0);
        d0 = done_cnt;
        repeat (300) @(posedge pclk);
        `CHK("free_runs", 1'b1, (done_cnt - d0) >= 8)
        rd(`SACC_OFF_CTRL_A, 32'hf0);
        // Compare counts just after a completion, before the next sample point
        wait_done(200);
        @(posedge pclk);
        `CHK("sample_count", done_cnt, sh_cnt)
        // Clock enable low freezes the running conversion
        d0 = done_cnt;
        ce_r <= 1'b0;
        repeat (40) @(posedge pclk);
        `CHK("ce_freeze", d0, done_cnt)
        ce_r <= 1'b1;
        wr(`SACC_OFF_CTRL_A, 32'h0);
        repeat (4) @(posedge pclk);
        `CHK("stopped", 1'b0, conv_busy)
        `CHK("half_idle", 1'b0, hrc)
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
endmodule // tb_sar_adc_conversion_control
